// ===== hw/edp_pkg.sv
package edp_pkg;

    // ****************************************************************
    // Instruction cycle timing
    // ****************************************************************
    localparam int EDP_CYC_LEN = 8;

    // ****************************************************************
    // Register map, byte offsets
    // ****************************************************************
    localparam logic [7:0] EDP_OFF_CTRL = 8'h00;
    localparam logic [7:0] EDP_OFF_STATUS = 8'h04;
    localparam logic [7:0] EDP_OFF_RDATA = 8'h08;
    localparam logic [7:0] EDP_OFF_HALTCNT = 8'h0C;

    // ****************************************************************
    // Field positions and reset values
    // ****************************************************************
    localparam int EDP_CTRL_SOFT_RST = 0;
    localparam int EDP_CTRL_FORCE_INH = 1;
    localparam logic [1:0] EDP_CTRL_RST = 2'h0;
    localparam int EDP_INSTR_HALT = 7;
    localparam int EDP_INSTR_INH = 6;
    localparam int EDP_INSTR_PRD = 5;

    // ****************************************************************
    // Cycle status, gray ordered
    // ****************************************************************
    typedef enum logic [1:0] {
        EDP_CK_FIRST = 2'b00,
        EDP_CK_FETCH = 2'b01,
        EDP_CK_OTHER = 2'b11,
        EDP_CK_HALT = 2'b10
    } edp_cycle_kind_t;

    // Requests sampled from the shared instruction data lines
    typedef struct packed {
        logic halt;
        logic inhibit;
        logic port_rd;
        logic [4:0] data;
    } edp_req_sample_t;

    // Port access presented by the core
    typedef struct packed {
        logic [3:0] num;
        logic wr;
        logic rd;
        logic [3:0] wdata;
        logic carry;
        logic page_lsb;
        logic first_cycle;
    } edp_core_port_t;

endpackage : edp_pkg

// ===== hw/edp_debug_port.sv
`timescale 1ns/10ps

// Notes on behaviour
// - Drive clock strobe and two timing state strobes out for external alignment.
// - Family select low picks CMOS-family timing; input defaults high.
// - Halt request on top instruction line, sampled only while state b high.
// - Accepted halt: no-op cycles, divider, timers and interrupt acceptance stopped.
// - Interrupt and count latches keep setting and clearing during halt or inhibit.
// - Inhibit sampled at state b; stops divider and timers, fetches still served.
// - Inhibit acts independently of halt.
// - Hold behaves as usual hold but the cycle clock keeps running.
// - Accepted fetch request gives one fetch cycle, also during halt.
// - Status 00 first, 01 fetch, 10 halt, 11 other, updated each cycle.
// - Master reset output follows the reset input.
// - Hold monitor output reflects hold operation.
// - Port number shown on a 4-bit output bus.
// - Port strobes on two lowest data outputs while state b high.
// - Write data on data outputs while state b low.
// - Top data output carries carry flag while state b high.
// - Third data output carries page address lsb while state b high.
module edp_debug_port
    import edp_pkg::*;
#(
    parameter int CYC_LEN = EDP_CYC_LEN
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // External debug pins
    input wire logic family_select_n,
    input wire logic [7:0] instr_data_in,
    input wire logic display_fetch_request_n,
    input wire logic hold_request_n,
    input wire logic reset_in_n,
    output logic timing_clock_out,
    output logic timing_state_a,
    output logic timing_state_b,
    output logic cycle_status_hi,
    output logic cycle_status_lo,
    output logic system_reset_out,
    output logic hold_monitor_out,
    output logic [3:0] port_number_out,
    output logic [3:0] data_out,
    // Core side
    input wire edp_core_port_t core_port,
    input wire logic irq_event,
    input wire logic irq_ack,
    output logic divider_run,
    output logic irq_accept_en,
    output logic irq_latched,
    output logic core_nop,
    output logic core_hold,
    output logic cycle_tick,
    output logic [4:0] ext_rd_data,
    output logic ext_rd_valid
);

    // Quarter points of the cycle must fall on whole clocks
    if (CYC_LEN < 4 || CYC_LEN % 4 != 0 || CYC_LEN > 64) begin : g_cyc_len_chk
        $error("CYC_LEN must be a multiple of 4 between 4 and 64");
    end

    localparam logic [5:0] PH_LAST = 6'(CYC_LEN - 1);
    localparam logic [5:0] PH_HALF = 6'(CYC_LEN / 2);
    localparam logic [5:0] PH_QTR = 6'(CYC_LEN / 4);
    localparam logic [5:0] PH_3QTR = 6'(3 * CYC_LEN / 4);

    // ****************************************************************
    // Timing generator
    // ****************************************************************
    logic [5:0] ph_q;
    logic [5:0] ph_d;
    logic st_b_d;
    logic st_a_d;
    logic sample_pt;
    logic tick;

    assign tick = (ph_q == PH_LAST);
    assign ph_d = tick ? 6'h00 : ph_q + 6'h01;
    assign st_a_d = (ph_d < PH_HALF);
    // CMOS-family timing centres the state b window in the cycle
    assign st_b_d = family_select_n ? (ph_d >= PH_HALF)
                                    : (ph_d >= PH_QTR && ph_d < PH_3QTR);
    // Sample on the last clock of the state b window
    assign sample_pt = timing_state_b && !st_b_d;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ph_q <= 6'h00;
            timing_clock_out <= 1'b0;
            timing_state_a <= 1'b0;
            timing_state_b <= 1'b0;
        end else begin
            ph_q <= ph_d;
            timing_clock_out <= ph_d[0];
            timing_state_a <= st_a_d;
            timing_state_b <= st_b_d;
        end
    end

    // ****************************************************************
    // Request sampling from the instruction data lines
    // ****************************************************************
    edp_req_sample_t smp;
    logic halt_q;
    logic inhibit_q;
    logic force_inh_q;
    logic soft_rst_q;
    logic stall;

    assign smp.halt = !instr_data_in[EDP_INSTR_HALT];
    assign smp.inhibit = !instr_data_in[EDP_INSTR_INH];
    assign smp.port_rd = !instr_data_in[EDP_INSTR_PRD];
    assign smp.data = instr_data_in[4:0];
    // Inhibit is kept apart from halt so it can run in normal operation
    assign stall = halt_q || inhibit_q || force_inh_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            halt_q <= 1'b0;
            inhibit_q <= 1'b0;
            ext_rd_data <= 5'h00;
            ext_rd_valid <= 1'b0;
        end else begin
            ext_rd_valid <= 1'b0;
            if (sample_pt) begin
                halt_q <= smp.halt;
                inhibit_q <= smp.inhibit;
                if (smp.port_rd) begin
                    ext_rd_data <= smp.data;
                    ext_rd_valid <= 1'b1;
                end
            end
        end
    end

    // ****************************************************************
    // Cycle kind, fetch, hold and core controls
    // ****************************************************************
    logic fetch_pend_q;
    logic hold_q;
    edp_cycle_kind_t kind_d;
    logic [15:0] halt_cnt_q;

    // Fetch outranks halt so the display keeps refreshing while halted
    assign kind_d = fetch_pend_q ? EDP_CK_FETCH :
                    halt_q ? EDP_CK_HALT :
                    core_port.first_cycle ? EDP_CK_FIRST : EDP_CK_OTHER;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fetch_pend_q <= 1'b0;
            hold_q <= 1'b0;
            cycle_status_hi <= 1'b1;
            cycle_status_lo <= 1'b1;
            cycle_tick <= 1'b0;
            core_nop <= 1'b0;
            halt_cnt_q <= 16'h0000;
        end else begin
            cycle_tick <= tick;
            if (sample_pt && !display_fetch_request_n) begin
                fetch_pend_q <= 1'b1;
            end else if (tick) begin
                fetch_pend_q <= 1'b0;
            end
            if (tick) begin
                {cycle_status_hi, cycle_status_lo} <= kind_d;
                core_nop <= (kind_d == EDP_CK_HALT);
                // Oscillator and phase counter never stop for hold
                hold_q <= !hold_request_n;
                if (kind_d == EDP_CK_HALT) begin
                    halt_cnt_q <= halt_cnt_q + 16'h0001;
                end
            end
        end
    end

    // ****************************************************************
    // Divider, interrupt latch and monitor outputs
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            divider_run <= 1'b0;
            irq_accept_en <= 1'b0;
            irq_latched <= 1'b0;
            core_hold <= 1'b0;
            hold_monitor_out <= 1'b0;
            system_reset_out <= 1'b1;
        end else begin
            divider_run <= !stall;
            irq_accept_en <= !stall;
            // Latch follows events whatever the stall state; set beats ack
            if (irq_event) begin
                irq_latched <= 1'b1;
            end else if (irq_ack) begin
                irq_latched <= 1'b0;
            end
            core_hold <= hold_q;
            hold_monitor_out <= hold_q;
            system_reset_out <= !reset_in_n || soft_rst_q;
        end
    end

    // ****************************************************************
    // Port number and multiplexed data outputs
    // ****************************************************************
    logic [3:0] dout_d;

    assign dout_d = st_b_d ? {core_port.carry, core_port.page_lsb, core_port.rd, core_port.wr}
                           : core_port.wdata;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_number_out <= 4'h0;
            data_out <= 4'h0;
        end else begin
            port_number_out <= core_port.num;
            data_out <= dout_d;
        end
    end

    // ****************************************************************
    // APB register file
    // ****************************************************************
    logic setup;
    logic wr_en;
    logic hit;
    logic [31:0] rd_mux;

    assign setup = psel && !penable;
    assign wr_en = psel && penable && pready && pwrite;
    assign hit = (paddr == EDP_OFF_CTRL) || (paddr == EDP_OFF_STATUS) ||
                 (paddr == EDP_OFF_RDATA) || (paddr == EDP_OFF_HALTCNT);
    assign rd_mux = (paddr == EDP_OFF_CTRL) ? {30'h0, force_inh_q, soft_rst_q} :
                    (paddr == EDP_OFF_STATUS) ? {26'h0, hold_q, inhibit_q, halt_q,
                                                 fetch_pend_q, cycle_status_hi,
                                                 cycle_status_lo} :
                    (paddr == EDP_OFF_RDATA) ? {27'h0, ext_rd_data} :
                    (paddr == EDP_OFF_HALTCNT) ? {16'h0, halt_cnt_q} : 32'h0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
            {force_inh_q, soft_rst_q} <= EDP_CTRL_RST;
        end else begin
            pready <= setup;
            pslverr <= setup && !hit;
            if (setup) begin
                prdata <= pwrite ? 32'h0 : rd_mux;
            end
            if (wr_en && paddr == EDP_OFF_CTRL) begin
                soft_rst_q <= pwdata[EDP_CTRL_SOFT_RST];
                force_inh_q <= pwdata[EDP_CTRL_FORCE_INH];
            end
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // A halt sampled on the tick is only shown at the following tick
    localparam int HALT_SHOW_MAX = 2 * CYC_LEN + 1;

    sequence halt_seen;
        sample_pt && smp.halt && !fetch_pend_q && !(!display_fetch_request_n);
    endsequence

    sequence halt_shown;
        ##[1:HALT_SHOW_MAX] (cycle_tick && cycle_status_hi && !cycle_status_lo);
    endsequence

    chk_halt_status: assert property (halt_seen |-> halt_shown)
        else $error("halt not reported in cycle status");

    chk_halt_stops_div: assert property (
        sample_pt && smp.halt |-> ##2 !divider_run && !irq_accept_en)
        else $error("divider still running during halt");

    chk_nop_matches: assert property (
        core_nop == (cycle_status_hi && !cycle_status_lo))
        else $error("no-op flag disagrees with halt status");

    chk_inh_stops_div: assert property (
        sample_pt && smp.inhibit |-> ##2 !divider_run)
        else $error("divider still running during inhibit");

    // A request still low at the tick is a fresh fetch, not a stuck one
    chk_fetch_one_cycle: assert property (
        tick && fetch_pend_q && !(sample_pt && !display_fetch_request_n) |=>
        cycle_status_lo && !cycle_status_hi ##1 !fetch_pend_q)
        else $error("fetch cycle not shown once");

    chk_irq_latch_set: assert property (irq_event |=> irq_latched)
        else $error("interrupt latch missed event");

    chk_port_strobes: assert property (
        timing_state_b |-> data_out[1:0] == $past({core_port.rd, core_port.wr}))
        else $error("port strobes not shown in state b");

    chk_strobes_on_b: assert property (
        timing_state_b |-> data_out[0] == $past(core_port.wr) &&
        data_out[3] == $past(core_port.carry))
        else $error("state b data output mux wrong");

    chk_lsb_on_b: assert property (
        timing_state_b |-> data_out[2] == $past(core_port.page_lsb))
        else $error("page lsb not shown");

    chk_wdata_on_a: assert property (
        !timing_state_b |-> data_out == $past(core_port.wdata))
        else $error("write data not shown");

    chk_rd_taken: assert property (
        sample_pt && smp.port_rd |=> ext_rd_valid && ext_rd_data == $past(smp.data))
        else $error("external read data not taken");

    chk_reset_follow: assert property (!reset_in_n |=> system_reset_out)
        else $error("master reset not driven");

    chk_clk_in_hold: assert property (
        hold_q |=> timing_clock_out != $past(timing_clock_out))
        else $error("clock strobe stopped during hold");

    chk_hold_mon: assert property (
        tick && !hold_request_n |=> ##1 hold_monitor_out)
        else $error("hold monitor not set");

    chk_port_num: assert property (##1 port_number_out == $past(core_port.num))
        else $error("port number not presented");

    chk_cycle_period: assert property (tick |-> ##CYC_LEN tick)
        else $error("instruction cycle period wrong");

endmodule : edp_debug_port

// ===== testbench/edp_ext_emu.sv
`timescale 1ns/10ps

// ****************************************************************
// External emulation logic facing the debug port
// ****************************************************************
module edp_ext_emu (
    // Clock and strobes
    input wire logic pclk,
    input wire logic presetn,
    input wire logic timing_state_b,
    input wire logic [3:0] port_number_out,
    input wire logic [3:0] data_out,
    // Requests from the bench
    input wire logic halt_n,
    input wire logic inh_n,
    input wire logic rd_n,
    input wire logic [4:0] rd_data,
    // Lines toward the device
    output logic [7:0] instr_data_in,
    output logic [3:0] wr_num_q
);
    logic [7:0] prog_q;

    // Program data moves every cycle so a stale sample cannot look right
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prog_q <= 8'h00;
        end else begin
            prog_q <= prog_q + 8'h35;
        end
    end

    // Requests only inside the state b window
    assign instr_data_in = timing_state_b ? {halt_n, inh_n, rd_n, rd_data} : prog_q;

    // Emulated port register select: port number qualified by write strobe
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_num_q <= 4'h0;
        end else if (timing_state_b && data_out[0]) begin
            wr_num_q <= port_number_out;
        end
    end
endmodule : edp_ext_emu

// ===== testbench/edp_debug_port_tb.sv
`timescale 1ns/10ps

module edp_debug_port_tb
    import edp_pkg::*;
;
    localparam int CL = 8;
    logic pclk = 1'b0, presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err, family_select_n = 1'b1, display_fetch_request_n = 1'b1;
    logic hold_request_n = 1'b1, reset_in_n = 1'b1, irq_event = 1'b0, irq_ack = 1'b0;
    logic halt_n = 1'b1, inh_n = 1'b1, rd_n = 1'b1;
    logic [4:0] rd_data = 5'h00, ext_rd_data;
    logic [7:0] instr_data_in;
    logic [3:0] port_number_out, data_out, wr_num_q;
    logic timing_clock_out, timing_state_a, timing_state_b, cycle_status_hi, cycle_status_lo;
    logic system_reset_out, hold_monitor_out, divider_run, irq_accept_en, irq_latched;
    logic core_nop, core_hold, cycle_tick, ext_rd_valid;
    edp_core_port_t core_port = '0;
    int error_cnt = 0, compares = 0;

    always #12.5 pclk = ~pclk;

    edp_debug_port #(.CYC_LEN(CL)) edp_debug_port_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .family_select_n(family_select_n), .instr_data_in(instr_data_in),
        .display_fetch_request_n(display_fetch_request_n), .hold_request_n(hold_request_n),
        .reset_in_n(reset_in_n), .timing_clock_out(timing_clock_out),
        .timing_state_a(timing_state_a), .timing_state_b(timing_state_b),
        .cycle_status_hi(cycle_status_hi), .cycle_status_lo(cycle_status_lo),
        .system_reset_out(system_reset_out), .hold_monitor_out(hold_monitor_out),
        .port_number_out(port_number_out), .data_out(data_out), .core_port(core_port),
        .irq_event(irq_event), .irq_ack(irq_ack), .divider_run(divider_run),
        .irq_accept_en(irq_accept_en), .irq_latched(irq_latched), .core_nop(core_nop),
        .core_hold(core_hold), .cycle_tick(cycle_tick), .ext_rd_data(ext_rd_data),
        .ext_rd_valid(ext_rd_valid));

    edp_ext_emu edp_ext_emu_inst (
        .pclk(pclk), .presetn(presetn), .timing_state_b(timing_state_b),
        .port_number_out(port_number_out), .data_out(data_out), .halt_n(halt_n),
        .inh_n(inh_n), .rd_n(rd_n), .rd_data(rd_data), .instr_data_in(instr_data_in),
        .wr_num_q(wr_num_q));

    // ****************************************************************
    // Shared helpers
    // ****************************************************************
    task summarize;
        if (error_cnt == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : summarize

    task check(input logic ok, input string msg);
        compares++;
        if (ok !== 1'b1) begin
            error_cnt++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask : check

    task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    // Lands two edges past the next cycle tick
    task cyc;
        int n;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (cycle_tick !== 1'b1 && n < 4 * CL);
        check(cycle_tick === 1'b1, "no cycle tick");
        repeat (2) @(posedge pclk);
    endtask : cyc

    function automatic logic st_is(input logic [1:0] s);
        return {cycle_status_hi, cycle_status_lo} === s;
    endfunction : st_is

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task t_regs;
        apb(1'b0, EDP_OFF_CTRL, 32'h0);
        check(rd === 32'h0 && err === 1'b0, "ctrl reset value");
        apb(1'b1, 8'h10, 32'hFFFF_FFFF);
        check(err === 1'b1, "unmapped write accepted");
        apb(1'b0, 8'h10, 32'h0);
        check(err === 1'b1 && rd === 32'h0, "unmapped read");
    endtask : t_regs

    task t_timing(input logic fs, input int ovl);
        int tg, na, nb, no;
        logic last;
        tg = 0; na = 0; nb = 0; no = 0;
        family_select_n <= fs;
        cyc();
        last = timing_clock_out;
        repeat (CL) begin
            @(posedge pclk);
            tg += int'(timing_clock_out !== last);
            last = timing_clock_out;
            na += int'(timing_state_a === 1'b1);
            nb += int'(timing_state_b === 1'b1);
            no += int'(timing_state_a === 1'b1 && timing_state_b === 1'b1);
        end
        check(tg == CL && na == CL / 2 && nb == CL / 2, "strobe shape");
        check(no == ovl, "family timing overlap");
        family_select_n <= 1'b1;
    endtask : t_timing

    // One fetch request during a held condition, other cycles must show code other
    task t_fetch(input logic [1:0] other);
        int nf, bad;
        nf = 0; bad = 0;
        display_fetch_request_n <= 1'b0;
        cyc();
        display_fetch_request_n <= 1'b1;
        repeat (4) begin
            nf += int'(st_is(2'b01));
            bad += int'(!st_is(2'b01) && !st_is(other));
            cyc();
        end
        check(nf == 1 && bad == 0, "single fetch cycle");
    endtask : t_fetch

    task t_halt;
        halt_n <= 1'b0;
        repeat (2) cyc();
        check(divider_run === 1'b0 && irq_accept_en === 1'b0, "halt gating");
        check(core_nop === 1'b1 && st_is(2'b10), "halt status");
        irq_event <= 1'b1;
        @(posedge pclk);
        irq_event <= 1'b0;
        repeat (2) @(posedge pclk);
        check(irq_latched === 1'b1, "latch frozen in halt");
        irq_ack <= 1'b1;
        @(posedge pclk);
        irq_ack <= 1'b0;
        repeat (2) @(posedge pclk);
        check(irq_latched === 1'b0, "latch not cleared");
        t_fetch(2'b10);
        apb(1'b0, EDP_OFF_HALTCNT, 32'h0);
        check(rd[15:0] != 16'h0, "halt count idle");
        halt_n <= 1'b1;
        repeat (2) cyc();
        check(divider_run === 1'b1 && core_nop === 1'b0, "halt release");
    endtask : t_halt

    task t_inh;
        inh_n <= 1'b0;
        repeat (2) cyc();
        check(divider_run === 1'b0 && irq_accept_en === 1'b0, "inhibit gating");
        check(core_nop === 1'b0 && st_is(2'b11), "inhibit ran as halt");
        t_fetch(2'b11);
        inh_n <= 1'b1;
        apb(1'b1, EDP_OFF_CTRL, 32'h2);
        repeat (2) cyc();
        check(divider_run === 1'b0, "forced inhibit");
        apb(1'b1, EDP_OFF_CTRL, 32'h0);
        core_port.first_cycle <= 1'b1;
        repeat (2) cyc();
        check(divider_run === 1'b1 && st_is(2'b00), "first cycle code");
        core_port.first_cycle <= 1'b0;
    endtask : t_inh

    task t_hold_rst;
        logic c0;
        hold_request_n <= 1'b0;
        repeat (2) cyc();
        check(hold_monitor_out === 1'b1 && core_hold === 1'b1, "hold monitor");
        c0 = timing_clock_out;
        @(posedge pclk);
        check(timing_clock_out !== c0, "clock stopped in hold");
        hold_request_n <= 1'b1;
        repeat (2) cyc();
        check(hold_monitor_out === 1'b0, "hold monitor stuck");
        reset_in_n <= 1'b0;
        repeat (3) @(posedge pclk);
        check(system_reset_out === 1'b1, "master reset");
        reset_in_n <= 1'b1;
        repeat (3) @(posedge pclk);
        check(system_reset_out === 1'b0, "master reset stuck");
        apb(1'b1, EDP_OFF_CTRL, 32'h1);
        @(posedge pclk);
        check(system_reset_out === 1'b1, "soft reset");
        apb(1'b1, EDP_OFF_CTRL, 32'h0);
    endtask : t_hold_rst

    task t_port(input logic [3:0] num, input logic w, input logic c, input logic [3:0] wd);
        core_port <= '{num: num, wr: w, rd: !w, wdata: wd, carry: c, page_lsb: !c,
                       first_cycle: 1'b0};
        cyc();
        check(port_number_out === num, "port number");
        repeat (CL) begin
            @(posedge pclk);
            if (timing_state_b === 1'b1) begin
                check(data_out === {c, !c, !w, w}, "strobe phase");
            end else begin
                check(data_out === wd, "write data");
            end
        end
    endtask : t_port

    task t_read;
        int n;
        n = 0;
        rd_n <= 1'b0;
        rd_data <= 5'h13;
        do begin
            @(posedge pclk);
            n++;
        end while (ext_rd_valid !== 1'b1 && n < 2 * CL);
        check(ext_rd_valid === 1'b1 && ext_rd_data === 5'h13, "ext read");
        rd_n <= 1'b1;
        apb(1'b0, EDP_OFF_RDATA, 32'h0);
        check(rd[4:0] === 5'h13, "read data register");
    endtask : t_read

    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        check(system_reset_out === 1'b0, "reset out after start");
        t_regs();
        t_timing(1'b1, 0);
        t_timing(1'b0, CL / 4);
        t_halt();
        t_inh();
        t_hold_rst();
        t_port(4'hA, 1'b1, 1'b1, 4'h5);
        check(wr_num_q === 4'hA, "port select");
        t_port(4'h3, 1'b0, 1'b0, 4'hC);
        check(wr_num_q === 4'hA, "port select moved on read");
        t_read();
        summarize();
    end

    // Whole run needs well under this many cycles
    initial begin
        #(25 * 40000);
        error_cnt++;
        summarize();
    end
endmodule : edp_debug_port_tb
